/* File: flash_pkg.sv */
/*
 flash_pkg: constants, register offsets, types for the flash program control block.
 assumes: used by flash_program_control and its two leaves via flash_pkg::name.
*/
package flash_pkg;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_COUNT = 256;
    localparam int BOOT_BYTES = 2048;
    localparam int USER_BYTES = PAGE_BYTES * PAGE_COUNT;
    localparam logic [11:0] OFS_FLASH_CONTROL = 12'h000;
    localparam logic [11:0] OFS_AUX_CONTROL_ONE = 12'h004;
    localparam logic [11:0] OFS_AUX_CONTROL_ZERO = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_PROGRAM_TIME = 12'h010;
    localparam logic [7:0] FLASH_CONTROL_RESET = 8'h00;
    localparam logic [3:0] KEY_ARM = 4'h5;
    localparam logic [3:0] KEY_FIRE = 4'hA;
    localparam logic [3:0] KEY_READ = 4'h0;
    localparam int KEY_LSB = 4;
    localparam int LATCH_MAP_BIT = 3;
    localparam int SPACE_LSB = 1;
    localparam int BUSY_BIT = 0;
    localparam int BOOT_SELECT_BIT = 5;
    localparam int EXT_RAM_BIT = 1;
    localparam logic [15:0] LATCH_WINDOW_TOP = 16'h7fff;
    localparam logic [15:0] SPARE_ROW_BASE = 16'hff80;
    localparam logic [15:0] BOOT_BASE = 16'hf800;
    localparam logic [15:0] SECURITY_ADDR = 16'h0000;
    localparam logic [7:0] SECURITY_SW_MASK = 8'hf0;
    localparam int ERASE_NS = 2000;
    localparam int CLK_NS = 20;
    localparam int ERASE_CYCLES = (ERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [31:0] BOOT_FILL = 32'h0000_0000;
    typedef enum logic [1:0] {SPACE_USER, SPACE_SPARE, SPACE_SECURITY, SPACE_RESERVED} space_t;
    typedef struct packed {
        logic [3:0] launch_key;
        logic latch_map_select;
        space_t space_select;
        logic program_in_progress;
    } flash_control_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] data;
    } mem_req_t;
endpackage : flash_pkg

/* File: column_latches.sv */
/*
 column_latches: one page of staging bytes with a loaded flag per byte.
 assumes: single clock, clear pulse after each programming run.
*/
`timescale 1ns/1ps
module column_latches (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_write,
    input wire logic [6:0] i_index,
    input wire logic [7:0] i_data,
    input wire logic i_clear,
    input wire logic [6:0] i_read_index,
    output logic [7:0] o_data,
    output logic o_loaded
);
    logic [7:0] bytes [flash_pkg::PAGE_BYTES];
    logic [flash_pkg::PAGE_BYTES-1:0] loaded;

    always_ff @(posedge i_clk) begin
        if (i_write) begin
            bytes[i_index] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            loaded <= '0;
        end else if (i_clear) begin
            loaded <= '0;
        end else if (i_write) begin
            loaded[i_index] <= 1'b1;
        end
    end

    assign o_data = bytes[i_read_index];

    assign o_loaded = loaded[i_read_index];
endmodule : column_latches

/* File: flash_array.sv */
/*
 flash_array: user array, spare row, security byte and boot bank storage.
 assumes: writes come one byte per cycle from the sequencer; boot bank has no write port.
*/
`timescale 1ns/1ps
module flash_array (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_user_write,
    input wire logic [14:0] i_user_addr,
    input wire logic i_spare_write,
    input wire logic i_security_write,
    input wire logic [7:0] i_wdata,
    input wire logic [14:0] i_read_addr,
    input wire logic [10:0] i_boot_addr,
    output logic [7:0] o_user_data,
    output logic [7:0] o_spare_data,
    output logic [7:0] o_boot_data,
    output logic [7:0] o_security
);
    logic [7:0] user_mem [flash_pkg::USER_BYTES];
    logic [7:0] spare_mem [flash_pkg::PAGE_BYTES];
    logic [7:0] boot_mem [flash_pkg::BOOT_BYTES];

    // boot bank has no in-system write port, it holds a fixed image
    initial begin
        foreach (boot_mem[i]) begin
            boot_mem[i] = flash_pkg::BOOT_FILL[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_user_write) begin
            user_mem[i_user_addr] <= i_wdata;
        end
        if (i_spare_write) begin
            spare_mem[i_user_addr[6:0]] <= i_wdata;
        end
        o_user_data <= user_mem[i_read_addr];
        o_spare_data <= spare_mem[i_read_addr[6:0]];
        o_boot_data <= boot_mem[i_boot_addr];
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_security <= flash_pkg::ERASED_BYTE;
        end else if (i_security_write) begin
            o_security <= (i_wdata & flash_pkg::SECURITY_SW_MASK) | (o_security & ~flash_pkg::SECURITY_SW_MASK);
        end
    end
endmodule : flash_array

/* File: flash_program_control.sv */
/*
 flash_program_control: apb registers, latch mapping, key launch, erase/program sequencer.
 assumes: apb master per protocol; cpu drives code reads and data writes on same clock.
*/
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module flash_program_control (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire flash_pkg::mem_req_t i_data_req,
    input wire logic [15:0] i_code_addr,
    input wire logic i_code_read,
    output logic [7:0] o_code_data,
    output logic o_code_ready,
    output logic o_data_to_external,
    output logic o_cpu_idle
);
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROGRAM, ST_DONE} state_t;

    flash_pkg::flash_control_t control;
    logic boot_bank_select;
    logic external_ram_select;
    logic armed;
    logic [7:0] page;
    logic [6:0] index;
    logic [$clog2(flash_pkg::ERASE_CYCLES+1)-1:0] timer;
    flash_pkg::space_t prog_space;
    state_t state;
    state_t next_state;
    logic [7:0] latch_data;
    logic latch_loaded;
    logic [7:0] user_data;
    logic [7:0] spare_data;
    logic [7:0] boot_data;
    logic [7:0] security;
    logic [14:0] read_addr;
    logic busy;
    logic apb_write;
    logic apb_read;
    logic latch_write;
    logic key_write;
    logic [3:0] key;
    logic program_step;
    logic [1:0] code_sel;
    logic code_pending;
    logic launch;
    logic erase_step;
    logic seq_write;
    logic [7:0] write_data;
    logic user_write;
    logic spare_write;
    logic security_write;

    function automatic logic in_latch_window(input logic [15:0] addr);
        in_latch_window = addr <= flash_pkg::LATCH_WINDOW_TOP;
    endfunction : in_latch_window

    // space field of a control word
    function automatic flash_pkg::space_t space_field(input logic [31:0] word);
        space_field = flash_pkg::space_t'(word[flash_pkg::SPACE_LSB +: 2]);
    endfunction : space_field

    // register offset match
    function automatic logic hits(input logic [11:0] addr, input logic [11:0] offset);
        hits = addr == offset;
    endfunction : hits

    // code read source for a fetch address
    function automatic logic [1:0] code_source(input logic [15:0] addr, input logic boot, input flash_pkg::space_t space);
        if (boot && addr >= flash_pkg::BOOT_BASE) begin
            code_source = flash_pkg::SPACE_RESERVED;
        end else begin
            code_source = space;
        end
    endfunction : code_source

    assign busy = state != ST_IDLE;
    assign apb_write = PSEL && PENABLE && PWRITE;
    assign apb_read = PSEL && !PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign key = PWDATA[flash_pkg::KEY_LSB +: 4];
    // register decode
    assign key_write = apb_write && hits(PADDR, flash_pkg::OFS_FLASH_CONTROL) && !busy;
    assign latch_write = i_data_req.valid && i_data_req.write && control.latch_map_select
        && in_latch_window(i_data_req.addr) && !busy;
    assign o_data_to_external = i_data_req.valid && !latch_write && !control.latch_map_select
        && external_ram_select;
    assign program_step = state == ST_PROGRAM && latch_loaded;
    assign launch = key_write && key == flash_pkg::KEY_FIRE && armed;
    // write port shared by the erase pass and the program pass
    assign erase_step = state == ST_ERASE && timer == '0 && latch_loaded;
    assign seq_write = erase_step || program_step;
    assign write_data = erase_step ? flash_pkg::ERASED_BYTE : latch_data;
    assign user_write = seq_write && prog_space == flash_pkg::SPACE_USER;
    assign spare_write = seq_write && prog_space == flash_pkg::SPACE_SPARE;
    assign security_write = seq_write && prog_space == flash_pkg::SPACE_SECURITY
        && index == '0;

    // control register and key sequence
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            control <= flash_pkg::FLASH_CONTROL_RESET;
            armed <= 1'b0;
            prog_space <= flash_pkg::SPACE_USER;
        end else if (key_write) begin
            control.latch_map_select <= PWDATA[flash_pkg::LATCH_MAP_BIT];
            control.space_select <= space_field(PWDATA);
            control.launch_key <= key;
            armed <= key == flash_pkg::KEY_ARM
                && space_field(PWDATA) != flash_pkg::SPACE_RESERVED;
            if (launch) begin
                prog_space <= space_field(PWDATA);
            end
        end else if (apb_write) begin
            armed <= 1'b0;
        end
    end

    // aux registers
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            boot_bank_select <= 1'b0;
            external_ram_select <= 1'b0;
        end else if (apb_write && hits(PADDR, flash_pkg::OFS_AUX_CONTROL_ONE)) begin
            boot_bank_select <= PWDATA[flash_pkg::BOOT_SELECT_BIT];
        end else if (apb_write && hits(PADDR, flash_pkg::OFS_AUX_CONTROL_ZERO)) begin
            external_ram_select <= PWDATA[flash_pkg::EXT_RAM_BIT];
        end
    end

    // page address from last latch write
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            page <= '0;
        end else if (latch_write) begin
            page <= i_data_req.addr[14:7];
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (launch) begin
                    next_state = ST_ERASE;
                end
            end
            ST_ERASE: begin
                if (timer == '0 && index == '1) begin
                    next_state = ST_PROGRAM;
                end
            end
            ST_PROGRAM: begin
                if (index == '1) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // byte walker and erase timer
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            index <= '0;
            timer <= '0;
        end else if (state == ST_IDLE) begin
            index <= '0;
            timer <= ($bits(timer))'(flash_pkg::ERASE_CYCLES);
        end else if (state == ST_ERASE) begin
            if (timer != '0) begin
                timer <= timer - 1'b1;
            end else begin
                index <= index + 1'b1;
            end
        end else if (state == ST_PROGRAM) begin
            index <= index + 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            o_cpu_idle <= 1'b0;
        end else begin
            o_cpu_idle <= next_state != ST_IDLE;
        end
    end

    column_latches u_latches (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_write(latch_write),
        .i_index(i_data_req.addr[6:0]),
        .i_data(i_data_req.data),
        .i_clear(state == ST_DONE),
        .i_read_index(index),
        .o_data(latch_data),
        .o_loaded(latch_loaded)
    );

    assign read_addr = busy ? {page, index} : i_code_addr[14:0];

    // loaded bytes only; unloaded bytes of the page keep their contents
    flash_array u_array (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_user_write(user_write),
        .i_user_addr({page, index}),
        .i_spare_write(spare_write),
        .i_security_write(security_write),
        .i_wdata(write_data),
        .i_read_addr(read_addr),
        .i_boot_addr(i_code_addr[10:0]),
        .o_user_data(user_data),
        .o_spare_data(spare_data),
        .o_boot_data(boot_data),
        .o_security(security)
    );

    // code read path, one cycle latency, refused while busy
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            code_pending <= 1'b0;
            code_sel <= '0;
        end else begin
            code_pending <= i_code_read && !busy;
            code_sel <= code_source(i_code_addr, boot_bank_select, control.space_select);
        end
    end

    assign o_code_ready = code_pending;

    always_comb begin
        case (code_sel)
            2'h0: o_code_data = user_data;
            2'h1: o_code_data = spare_data;
            2'h2: o_code_data = security;
            default: o_code_data = boot_data;
        endcase
    end

    // apb read data
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            PRDATA <= '0;
        end else if (apb_read) begin
            case (PADDR)
                flash_pkg::OFS_FLASH_CONTROL: PRDATA <= {24'h0000_00, control.launch_key,
                    control.latch_map_select, control.space_select, busy};
                flash_pkg::OFS_AUX_CONTROL_ONE: PRDATA <= {26'h000_0000, boot_bank_select, 5'h00};
                flash_pkg::OFS_AUX_CONTROL_ZERO: PRDATA <= {30'h0000_0000, external_ram_select, 1'b0};
                flash_pkg::OFS_STATUS: PRDATA <= {24'h0000_00, security};
                default: PRDATA <= '0;
            endcase
        end
    end
endmodule : flash_program_control

/* File: flash_checker.sv */
/*
 flash_checker: launch, idle and fetch assertions on the top ports.
 assumes: bound to flash_program_control, single clock domain.
*/
`timescale 1ns/1ps
module flash_checker (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic i_code_read,
    input wire logic o_code_ready,
    input wire logic o_data_to_external,
    input wire logic o_cpu_idle
);
    logic armed;
    logic wr_ctl;
    logic fire;
    assign wr_ctl = PSEL && PENABLE && PWRITE && PADDR == flash_pkg::OFS_FLASH_CONTROL && !o_cpu_idle;
    assign fire = wr_ctl && armed && PWDATA[7:4] == flash_pkg::KEY_FIRE && PWDATA[2:1] != 2'b11;
    // any write other than the arming key disarms
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            armed <= 1'b0;
        end else if (PSEL && PENABLE && PWRITE) begin
            armed <= wr_ctl && PWDATA[7:4] == flash_pkg::KEY_ARM;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    property p_launch; fire |=> o_cpu_idle; endproperty
    a_launch: assert property (p_launch) else $error("launch did not idle the core");
    property p_no_launch; wr_ctl && !fire |=> !o_cpu_idle; endproperty
    a_no_launch: assert property (p_no_launch) else $error("idle without a key pair");
    property p_idle_hold; $rose(o_cpu_idle) |-> o_cpu_idle [*8]; endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle dropped early");
    property p_idle_end; $rose(o_cpu_idle) |-> ##[1:1000] !o_cpu_idle; endproperty
    a_idle_end: assert property (p_idle_end) else $error("idle never released");
    property p_fetch_refused; i_code_read && o_cpu_idle |=> !o_code_ready; endproperty
    a_fetch_refused: assert property (p_fetch_refused) else $error("fetch served while busy");
    property p_fetch_answer; i_code_read && !o_cpu_idle |=> o_code_ready; endproperty
    a_fetch_answer: assert property (p_fetch_answer) else $error("fetch not answered");
    property p_ready_cause; o_code_ready |-> $past(i_code_read); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without a fetch");
    property p_latch_map; wr_ctl && PWDATA[flash_pkg::LATCH_MAP_BIT] |=> !o_data_to_external; endproperty
    a_latch_map: assert property (p_latch_map) else $error("external ram not overridden");
endmodule : flash_checker
bind flash_program_control flash_checker chk_i (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .i_code_read(i_code_read),
    .o_code_ready(o_code_ready), .o_data_to_external(o_data_to_external), .o_cpu_idle(o_cpu_idle));

/* File: cpu_core_model.sv */
/*
 cpu_core_model: processor side issuing code fetches and data writes.
 assumes: tasks called just after a rising edge.
*/
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic i_clk,
    input wire logic i_cpu_idle,
    input wire logic [7:0] i_code_data,
    input wire logic i_code_ready,
    output flash_pkg::mem_req_t o_data_req,
    output logic [15:0] o_code_addr,
    output logic o_code_read
);
    initial begin
        o_data_req = '0;
        o_code_addr = 16'h0000;
        o_code_read = 1'b0;
    end
    task automatic fetch(input logic [15:0] a, input logic insist, output logic [7:0] d, output logic ok);
        int k;
        k = 0;
        ok = 1'b0;
        d = 8'h00;
        // interrupts are off, so unless insist is set the core sleeps until programming ends
        while (i_cpu_idle === 1'b1 && !insist && k < 2000) begin
            @(posedge i_clk);
            k++;
        end
        o_code_addr <= a;
        o_code_read <= 1'b1;
        @(posedge i_clk);
        o_code_read <= 1'b0;
        o_code_addr <= ~a;
        for (k = 0; k < 2; k++) begin
            #1;
            if (i_code_ready === 1'b1 && !ok) begin
                ok = 1'b1;
                d = i_code_data;
            end
            @(posedge i_clk);
        end
    endtask : fetch
    task automatic store(input logic [15:0] a, input logic [7:0] d);
        o_data_req <= '{valid: 1'b1, write: 1'b1, addr: a, data: d};
        @(posedge i_clk);
        o_data_req <= '{valid: 1'b0, write: 1'b0, addr: ~a, data: ~d};
        @(posedge i_clk);
    endtask : store
endmodule : cpu_core_model

/* File: tb_flash_program_control.sv */
/*
 tb_flash_program_control: key table, page, spare row, security and boot checks.
 assumes: apb answers with pready, fetches through the core model.
*/
`timescale 1ns/1ps
module tb_flash_program_control;
    localparam logic [11:0] CTL = flash_pkg::OFS_FLASH_CONTROL;
    typedef struct packed {
        logic [7:0] k1;
        logic [7:0] k2;
        logic busy;
    } row_t;
    row_t rows [5] = '{'{8'ha0, 8'ha0, 1'b0}, '{8'h50, 8'h50, 1'b0}, '{8'h00, 8'ha0, 1'b0},
        '{8'h56, 8'ha6, 1'b0}, '{8'h52, 8'ha2, 1'b1}};
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    flash_pkg::mem_req_t data_req;
    logic [15:0] code_addr;
    logic code_read;
    logic [7:0] code_data;
    logic code_ready;
    logic to_ext;
    logic cpu_idle;
    logic [31:0] r;
    logic [7:0] d;
    logic [7:0] p7;
    logic ok;
    int n_fail = 0;
    int cmp_count = 0;
    flash_program_control dut (.I_CLK(i_clk), .I_RESET_N(i_reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(),
        .i_data_req(data_req), .i_code_addr(code_addr), .i_code_read(code_read), .o_code_data(code_data),
        .o_code_ready(code_ready), .o_data_to_external(to_ext), .o_cpu_idle(cpu_idle));
    cpu_core_model cpu (.i_clk(i_clk), .i_cpu_idle(cpu_idle), .i_code_data(code_data),
        .i_code_ready(code_ready), .o_data_req(data_req), .o_code_addr(code_addr), .o_code_read(code_read));
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask : apb
    task automatic wait_idle();
        int k;
        k = 0;
        while (cpu_idle !== 1'b0 && k < 2000) begin
            @(posedge i_clk);
            k++;
        end
    endtask : wait_idle
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        apb(1'b0, CTL, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        apb(1'b0, flash_pkg::OFS_STATUS, 32'h0000_0000, r);
        chk(r, 32'h0000_00ff);
        apb(1'b0, 12'h040, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, CTL, {24'h00_0000, rows[i].k1}, r);
            apb(1'b1, CTL, {24'h00_0000, rows[i].k2}, r);
            apb(1'b0, CTL, 32'h0000_0000, r);
            chk(r & 32'h0000_0001, {31'h0000_0000, rows[i].busy});
            wait_idle();
        end
        $display("test key table done");
        apb(1'b1, CTL, 32'h0000_0008, r);
        apb(1'b1, flash_pkg::OFS_AUX_CONTROL_ZERO, 32'h0000_0002, r);
        cpu.fetch(16'h0187, 1'b0, p7, ok);
        fork
            cpu.store(16'h0105, 8'h11);
            begin
                #1;
                chk({31'h0000_0000, to_ext}, 32'h0000_0000);
            end
        join
        cpu.store(16'h0186, 8'h22);
        apb(1'b1, CTL, 32'h0000_0058, r);
        apb(1'b1, CTL, 32'h0000_00a8, r);
        chk({31'h0000_0000, cpu_idle}, 32'h0000_0001);
        cpu.fetch(16'h0000, 1'b1, d, ok);
        chk({31'h0000_0000, ok}, 32'h0000_0000);
        apb(1'b0, CTL, 32'h0000_0000, r);
        chk(r & 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, CTL, 32'h0000_0000, r);
        wait_idle();
        apb(1'b0, CTL, 32'h0000_0000, r);
        chk(r & 32'h0000_0009, 32'h0000_0008);
        cpu.fetch(16'h0185, 1'b0, d, ok);
        chk({24'h00_0000, d}, 32'h0000_0011);
        cpu.fetch(16'h0186, 1'b0, d, ok);
        chk({24'h00_0000, d}, 32'h0000_0022);
        cpu.fetch(16'h0187, 1'b0, d, ok);
        chk({24'h00_0000, d}, {24'h00_0000, p7});
        apb(1'b1, CTL, 32'h0000_0000, r);
        fork
            cpu.store(16'h0185, 8'h77);
            begin
                #1;
                chk({31'h0000_0000, to_ext}, 32'h0000_0001);
            end
        join
        cpu.fetch(16'h0185, 1'b0, d, ok);
        chk({24'h00_0000, d}, 32'h0000_0011);
        $display("test user page done");
        apb(1'b1, CTL, 32'h0000_000a, r);
        cpu.store(16'h0005, 8'h33);
        apb(1'b1, CTL, 32'h0000_005a, r);
        apb(1'b1, CTL, 32'h0000_00aa, r);
        wait_idle();
        apb(1'b1, CTL, 32'h0000_0002, r);
        cpu.fetch(16'hff85, 1'b0, d, ok);
        chk({24'h00_0000, d}, 32'h0000_0033);
        $display("test spare row done");
        apb(1'b1, CTL, 32'h0000_000c, r);
        cpu.store(16'h0000, 8'h3c);
        apb(1'b1, CTL, 32'h0000_005c, r);
        apb(1'b1, CTL, 32'h0000_00ac, r);
        wait_idle();
        apb(1'b0, flash_pkg::OFS_STATUS, 32'h0000_0000, r);
        chk(r, 32'h0000_003f);
        $display("test security done");
        apb(1'b1, flash_pkg::OFS_AUX_CONTROL_ONE, 32'h0000_0020, r);
        apb(1'b1, CTL, 32'h0000_0000, r);
        cpu.fetch(16'hf800, 1'b0, d, ok);
        chk({24'h00_0000, d}, {24'h00_0000, flash_pkg::BOOT_FILL[7:0]});
        $display("test boot bank done");
        stop_test();
    end
endmodule : tb_flash_program_control
